// ==== rtl/tas_defs.svh ====
// Constants of the thermal alarm status block: register offsets, field
// positions, reset values and read answers.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TAS_DEFS_SVH
`define TAS_DEFS_SVH

// Register offsets (command byte values).
`define TAS_OFS_COMMON_STATUS  8'h02
`define TAS_OFS_ALARM_ONE      8'h08
`define TAS_OFS_ALARM_TWO      8'h09
`define TAS_OFS_ALARM_THREE    8'h0A
`define TAS_OFS_MODEL_STATUS   8'h38

// Field positions inside the alarm status registers.
`define TAS_BIT_LOCAL          0
`define TAS_BIT_REMOTE_A       1
`define TAS_BIT_REMOTE_B       2

// Field positions of the summary flags in the common status register.
`define TAS_BIT_SUM_ONE        1
`define TAS_BIT_SUM_TWO        2
`define TAS_BIT_SUM_THREE      3

// Reset values and the answer to an unmapped command byte.
`define TAS_RST_STATUS         3'h0
`define TAS_RST_DATA           8'h00
`define TAS_UNMAPPED_DATA      8'h00

// Default width of readings, limits and hysteresis.
`define TAS_TEMP_W             11

`endif

// ==== rtl/tas_pkg.sv ====
// Types shared by the thermal alarm status block.
// Assumes tas_defs.svh is on the include path.
`include "tas_defs.svh"
`default_nettype none

package tas_pkg;

    // One flag per channel, in register bit order (remote B at bit 2).
    typedef struct packed {
        logic remoteB;
        logic remoteA;
        logic localChan;
    } tas_chan_t;

    // Read request from the serial bus front end.
    typedef struct packed {
        logic       strobe;
        logic [7:0] addr;
    } tas_rd_req_t;

endpackage

`default_nettype wire

// ==== rtl/thermal_alarm_status.sv ====
// Alarm status logic: three alarm status registers with hysteresis,
// alarm output gating by masks, summary flags and diode model flags.
// Assumes readings, limits, hysteresis and masks come from logic on the
// same clock, and that a serial bus front end issues command-byte reads.
`include "tas_defs.svh"
`timescale 1ns/10ps
`default_nettype none

// Function
// - First alarm output follows unmasked first status bits
// - Second alarm output follows unmasked second status bits
// - Third alarm output follows unmasked third status bits
// - First status register read-only, bits 7..3 zero
// - Second status register read-only, upper bits zero
// - Third status register read-only, upper bits zero
// - Remote bit sets when reading reaches its limit
// - Local bit sets when reading reaches its limit
// - Bit clears below limit minus shared hysteresis
// - Model status read-only, bits 2..1 only
// - Mismatch flag: compensation on with discrete transistor
// - Set mask bit blocks channel from output
// - Summary flag shows any bit set per register
module thermal_alarm_status
    import tas_pkg::*;
#(
    parameter int TEMP_W = `TAS_TEMP_W
) (
    // Clock and reset.
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Readings of the local, remote A and remote B channels.
    input  wire logic [TEMP_W-1:0] localReading,
    input  wire logic [TEMP_W-1:0] remoteAReading,
    input  wire logic [TEMP_W-1:0] remoteBReading,
    // Limits: one local limit for all alarms, one per remote channel per alarm, index 0..2 for alarms one..three.
    input  wire logic [TEMP_W-1:0] localLimit,
    input  wire logic [TEMP_W-1:0] remoteALimit [3],
    input  wire logic [TEMP_W-1:0] remoteBLimit [3],
    input  wire logic [TEMP_W-1:0] sharedHysteresis,
    // Channel masks per alarm; a set bit blocks the channel.
    input  wire tas_chan_t         alarmOneBlock,
    input  wire tas_chan_t         alarmTwoBlock,
    input  wire tas_chan_t         alarmThreeBlock,
    // Diode model state of the two remote channels.
    input  wire logic              remoteABetaComp,
    input  wire logic              remoteBBetaComp,
    input  wire logic              remoteADiscreteSeen,
    input  wire logic              remoteBDiscreteSeen,
    // Register read port.
    input  wire tas_rd_req_t       rdReq,
    output logic [7:0]             rdData,
    output logic                   rdValid,
    // Alarm outputs, active low.
    output logic                   alarmOutOneN,
    output logic                   alarmOutTwoN,
    output logic                   alarmOutThreeN,
    // Summary flags, one per alarm status register.
    output logic [2:0]             summaryFlags
);

    // Threshold tests on one reading against one limit.
    function automatic logic reachesLimit(
        input logic [TEMP_W-1:0] reading,
        input logic [TEMP_W-1:0] limit
    );
        reachesLimit = (reading >= limit);
    endfunction

    // One extra bit keeps reading plus hysteresis from wrapping, so a limit
    // smaller than the hysteresis never clears a bit by underflow.
    function automatic logic belowRelease(
        input logic [TEMP_W-1:0] reading,
        input logic [TEMP_W-1:0] limit,
        input logic [TEMP_W-1:0] hyst
    );
        belowRelease = ({1'b0, reading} + {1'b0, hyst}) < {1'b0, limit};
    endfunction

    // Next value of one status bit: set, clear or hold. The set and clear
    // tests never hold together, and a reading inside the band holds.
    function automatic logic nextFlag(
        input logic              cur,
        input logic [TEMP_W-1:0] reading,
        input logic [TEMP_W-1:0] limit,
        input logic [TEMP_W-1:0] hyst
    );
        if (reachesLimit(reading, limit)) begin
            nextFlag = 1'b1;
        end else if (belowRelease(reading, limit, hyst)) begin
            nextFlag = 1'b0;
        end else begin
            nextFlag = cur;
        end
    endfunction

    // Status flags and masks per alarm, index 0..2 for alarms one..three.
    tas_chan_t  alarmStatus_q [3];
    tas_chan_t  alarmStatus_d [3];
    tas_chan_t  alarmBlock    [3];
    logic [2:0] alarmActive;
    logic [1:0] modelMismatch_q;
    logic [1:0] modelMismatch_d;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic       rdValid_q;
    logic [7:0] alarmOneByte;
    logic [7:0] alarmTwoByte;
    logic [7:0] alarmThreeByte;
    logic [7:0] modelByte;
    logic [7:0] commonByte;
    // Hit wires of the read address decode.
    logic       hitCommon;
    logic       hitOne;
    logic       hitTwo;
    logic       hitThree;
    logic       hitModel;
    logic       hitNone;

    // Masks gathered into an array so the alarm loop can index them.
    assign alarmBlock[0] = alarmOneBlock;
    assign alarmBlock[1] = alarmTwoBlock;
    assign alarmBlock[2] = alarmThreeBlock;

    // Status bit updates for each alarm; the local limit is shared by all
    // three alarms while each remote channel has a limit per alarm.
    for (genvar a = 0; a < 3; a++) begin : gAlarm
        assign alarmStatus_d[a].localChan = nextFlag(alarmStatus_q[a].localChan,
            localReading, localLimit, sharedHysteresis);
        assign alarmStatus_d[a].remoteA = nextFlag(alarmStatus_q[a].remoteA,
            remoteAReading, remoteALimit[a],
            sharedHysteresis);
        assign alarmStatus_d[a].remoteB = nextFlag(alarmStatus_q[a].remoteB,
            remoteBReading, remoteBLimit[a],
            sharedHysteresis);
        // An alarm is active while any unblocked status bit is set.
        assign alarmActive[a] =
            |(alarmStatus_q[a] & ~alarmBlock[a]);
        assign summaryFlags[a] = |alarmStatus_q[a];
    end

    // Status registers hold their flags across cycles. Masks never reach
    // them, so a blocked channel still shows its status and its summary.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                alarmStatus_q[i] <= `TAS_RST_STATUS;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                alarmStatus_q[i] <= alarmStatus_d[i];
            end
        end
    end

    // Alarm pins drive low while their alarm is active. They are
    // combinational, so a mask change acts in the same cycle.
    assign alarmOutOneN   = ~alarmActive[0];
    assign alarmOutTwoN   = ~alarmActive[1];
    assign alarmOutThreeN = ~alarmActive[2];

    // Model mismatch: compensation enabled while a discrete part is seen.
    // The flags are registered so a read sees a value settled at an edge.
    assign modelMismatch_d = {remoteBBetaComp & remoteBDiscreteSeen,
                              remoteABetaComp & remoteADiscreteSeen};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            modelMismatch_q <= 2'b00;
        end else begin
            modelMismatch_q <= modelMismatch_d;
        end
    end

    // Register images; unused bits read as zero. Bit 0 of the common
    // register belongs to the fault register outside this block.
    assign alarmOneByte   = {5'b0_0000, alarmStatus_q[0]};
    assign alarmTwoByte   = {5'b0_0000, alarmStatus_q[1]};
    assign alarmThreeByte = {5'b0_0000, alarmStatus_q[2]};
    assign modelByte      = {5'b0_0000, modelMismatch_q, 1'b0};
    assign commonByte     = {4'h0, summaryFlags, 1'b0};

    // Read address decode, one hit wire per mapped register.
    assign hitCommon = (rdReq.addr == `TAS_OFS_COMMON_STATUS);
    assign hitOne    = (rdReq.addr == `TAS_OFS_ALARM_ONE);
    assign hitTwo    = (rdReq.addr == `TAS_OFS_ALARM_TWO);
    assign hitThree  = (rdReq.addr == `TAS_OFS_ALARM_THREE);
    assign hitModel  = (rdReq.addr == `TAS_OFS_MODEL_STATUS);
    assign hitNone   = ~(hitCommon | hitOne | hitTwo | hitThree | hitModel);

    // Read data selection; writes do not exist on this port, so all
    // registers stay read-only and an unmapped byte reads a fixed answer.
    assign rdData_d = ({8{hitCommon}} & commonByte)
                    | ({8{hitOne}} & alarmOneByte)
                    | ({8{hitTwo}} & alarmTwoByte)
                    | ({8{hitThree}} & alarmThreeByte)
                    | ({8{hitModel}} & modelByte)
                    | ({8{hitNone}} & `TAS_UNMAPPED_DATA);

    // Read data is captured on the strobe and held until the next read.
    // Every strobe answers, so the host never waits on a legal byte.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q  <= `TAS_RST_DATA;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= rdReq.strobe;
            if (rdReq.strobe) begin
                rdData_q <= rdData_d;
            end
        end
    end

    assign rdData  = rdData_q;
    assign rdValid = rdValid_q;

endmodule

`default_nettype wire

// ==== testbench/tas_chk.sv ====
// Checker of alarm pins, summary flags and read port of the status block.
// Bound onto thermal_alarm_status; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module tas_chk
    import tas_pkg::*;
#(parameter int TEMP_W = 11) (
    // Clock and reset.
    input wire logic              sys_clk,
    input wire logic              rst_n,
    // Readings, limits and masks.
    input wire logic [TEMP_W-1:0] localReading,
    input wire logic [TEMP_W-1:0] localLimit,
    input wire logic [TEMP_W-1:0] remoteAReading,
    input wire logic [TEMP_W-1:0] remoteALimit [3],
    input wire tas_chan_t         alarmOneBlock,
    input wire tas_chan_t         alarmTwoBlock,
    // Read port, pins and flags.
    input wire tas_rd_req_t       rdReq,
    input wire logic [7:0]        rdData,
    input wire logic              rdValid,
    input wire logic              alarmOutOneN,
    input wire logic              alarmOutTwoN,
    input wire logic              alarmOutThreeN,
    input wire logic [2:0]        summaryFlags
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // A read is a taken strobe followed by one answer.
    sequence sTaken; rdReq.strobe; endsequence
    sequence sStatus; sTaken ##0 rdReq.addr inside {8'h08, 8'h09, 8'h0A};
    endsequence
    a_out_one: assert property (!summaryFlags[0] |-> alarmOutOneN)
        else $error("Alarm one active with its status clear.");
    a_out_two: assert property (!summaryFlags[1] |-> alarmOutTwoN)
        else $error("Alarm two active with its status clear.");
    a_out_three: assert property (!summaryFlags[2] |-> alarmOutThreeN)
        else $error("Alarm three active with its status clear.");
    a_local_set: assert property (localReading >= localLimit |=>
        summaryFlags[0] && (alarmOneBlock.localChan || !alarmOutOneN))
        else $error("Local reading at limit did not raise alarm one.");
    a_out_two_on: assert property (
        summaryFlags[1] && alarmTwoBlock == 3'h0 |-> !alarmOutTwoN)
        else $error("Alarm two idle with an unmasked status bit set.");
    a_remote_set: assert property (remoteAReading >= remoteALimit[0]
        |=> summaryFlags[0]) else $error("Remote A set missed.");
    a_mask_all: assert property (
        alarmOneBlock == 3'h7 |-> alarmOutOneN)
        else $error("Fully masked alarm one still active.");
    a_read_answer: assert property (sTaken |=> rdValid)
        else $error("Read strobe got no answer.");
    a_valid_cause: assert property (rdValid |-> $past(rdReq.strobe))
        else $error("Answer without a strobe.");
    a_status_high: assert property (
        sStatus |=> rdData[7:3] == 5'h00)
        else $error("Status register upper bits not zero.");
    // A read of the common register answers with the flags of its edge.
    sequence sCommon; sTaken ##0 rdReq.addr == 8'h02; endsequence
    a_summary_read: assert property (
        sCommon |=> rdData[3:1] == $past(summaryFlags)
        && rdData[7:4] == 4'h0 && !rdData[0])
        else $error("Common status does not mirror the summary flags.");
endmodule
bind thermal_alarm_status tas_chk #(.TEMP_W(TEMP_W)) tas_chk_inst (.*);
`default_nettype wire

// ==== testbench/tas_host.sv ====
// Serial bus host model issuing command-byte reads.
// Assumes the block's read port on the same clock.
`timescale 1ns/10ps
`default_nettype none
module tas_host
    import tas_pkg::*;
(
    // Clock.
    input  wire logic       sys_clk,
    // Read port of the block.
    output var tas_rd_req_t rdReq,
    input  wire logic [7:0] rdData,
    input  wire logic       rdValid
);
    initial rdReq = '0;
    // Pulses the strobe, then waits a bounded time for the answer.
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output bit ok);
        ok = 0;
        d = 8'h00;
        @(posedge sys_clk);
        #1 rdReq = '{strobe: 1'b1, addr: a};
        @(posedge sys_clk);
        // The address is not held after the strobe, so it is scrambled.
        #1 rdReq = '{strobe: 1'b0, addr: ~a};
        for (int i = 0; i < 4 && !ok; i++) begin
            ok = (rdValid === 1'b1);
            d = rdData;
            if (!ok) @(posedge sys_clk) #1;
        end
    endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Testbench of the alarm status block: reads registers, checks pins.
// Assumes the package, the design, the host model and the checker.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import tas_pkg::*;
    logic             sys_clk = 0, rst_n = 0;
    logic [10:0]      localReading = 0, remoteAReading = 0;
    logic [10:0]      remoteBReading = 0, localLimit = 11'h064;
    logic [10:0]      sharedHysteresis = 11'h00A;
    logic [10:0]      remoteALimit [3] = '{11'h064, 11'h0C8, 11'h12C};
    logic [10:0]      remoteBLimit [3] = '{11'h096, 11'h0FA, 11'h15E};
    tas_chan_t        alarmOneBlock = '0, alarmTwoBlock = '0;
    tas_chan_t        alarmThreeBlock = '0;
    logic             remoteABetaComp = 0, remoteBBetaComp = 0;
    logic             remoteADiscreteSeen = 0, remoteBDiscreteSeen = 0;
    wire tas_rd_req_t rdReq;
    logic [7:0]       rdData;
    logic             rdValid, alarmOutOneN, alarmOutTwoN, alarmOutThreeN;
    logic [2:0]       summaryFlags;
    int               n_fail = 0, checks = 0;
    thermal_alarm_status thermal_alarm_status_inst (
        .sys_clk             (sys_clk),
        .rst_n               (rst_n),
        .localReading        (localReading),
        .remoteAReading      (remoteAReading),
        .remoteBReading      (remoteBReading),
        .localLimit          (localLimit),
        .remoteALimit        (remoteALimit),
        .remoteBLimit        (remoteBLimit),
        .sharedHysteresis    (sharedHysteresis),
        .alarmOneBlock       (alarmOneBlock),
        .alarmTwoBlock       (alarmTwoBlock),
        .alarmThreeBlock     (alarmThreeBlock),
        .remoteABetaComp     (remoteABetaComp),
        .remoteBBetaComp     (remoteBBetaComp),
        .remoteADiscreteSeen (remoteADiscreteSeen),
        .remoteBDiscreteSeen (remoteBDiscreteSeen),
        .rdReq               (rdReq),
        .rdData              (rdData),
        .rdValid             (rdValid),
        .alarmOutOneN        (alarmOutOneN),
        .alarmOutTwoN        (alarmOutTwoN),
        .alarmOutThreeN      (alarmOutThreeN),
        .summaryFlags        (summaryFlags)
    );
    tas_host tas_host_inst (
        .sys_clk (sys_clk),
        .rdReq   (rdReq),
        .rdData  (rdData),
        .rdValid (rdValid)
    );
    initial forever #20 sys_clk = ~sys_clk;
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("Checks %0d, mismatches %0d.", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Compares one byte.
    task automatic cmp(input logic [7:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    // Reads a register and compares the answer; no answer ends the run.
    task automatic rdChk(input logic [7:0] a, exp);
        logic [7:0] d;
        bit         ok;
        tas_host_inst.rd(a, d, ok);
        if (!ok) begin
            n_fail++;
            $display("MISMATCH at %0t: no answer to a read", $time);
            results();
        end
        cmp(d, exp);
    endtask
    // Compares the pins, ordered three, two, one.
    task automatic pinChk(input logic [2:0] exp);
        cmp({5'h0, alarmOutThreeN, alarmOutTwoN, alarmOutOneN}, {5'h0, exp});
    endtask
    // Main sequence.
    initial begin
        repeat (5) @(posedge sys_clk);
        #1 rst_n = 1;
        for (int i = 0; i < 3; i++) begin
            rdChk(8'h08 + 8'(i), 8'h00);
        end
        rdChk(8'h38, 8'h00);
        pinChk(3'h7);
        localReading = 11'h064;
        remoteAReading = 11'h0FA;
        remoteBReading = 11'h0FA;
        rdChk(8'h08, 8'h07);
        rdChk(8'h09, 8'h07);
        rdChk(8'h0A, 8'h01);
        rdChk(8'h02, 8'h0E);
        pinChk(3'h0);
        cmp({5'h00, summaryFlags}, 8'h07);
        alarmOneBlock = 3'h7;
        alarmThreeBlock = 3'h1;
        rdChk(8'h08, 8'h07);
        pinChk(3'h5);
        alarmOneBlock = 3'h0;
        alarmThreeBlock = 3'h0;
        localReading = 11'h05A;
        remoteBReading = 11'h0F0;
        rdChk(8'h0A, 8'h01);
        rdChk(8'h09, 8'h07);
        localReading = 11'h059;
        remoteBReading = 11'h0EF;
        rdChk(8'h0A, 8'h00);
        rdChk(8'h09, 8'h02);
        rdChk(8'h02, 8'h06);
        pinChk(3'h4);
        cmp({5'h00, summaryFlags}, 8'h03);
        remoteABetaComp = 1;
        remoteADiscreteSeen = 1;
        rdChk(8'h38, 8'h02);
        remoteBBetaComp = 1;
        remoteBDiscreteSeen = 1;
        remoteADiscreteSeen = 0;
        rdChk(8'h38, 8'h04);
        rdChk(8'h55, 8'h00);
        // Reset in mid-run clears every status bit and releases the pins.
        @(posedge sys_clk) #1 rst_n = 0;
        @(negedge sys_clk);
        pinChk(3'h7);
        cmp({5'h00, summaryFlags}, 8'h00);
        @(posedge sys_clk) #1 rst_n = 1;
        rdChk(8'h09, 8'h02);
        results();
    end
endmodule
`default_nettype wire
